/* tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module tb
  import vic_pkg::*;
;
  logic                    clk = 1'b0;
  logic                    rst_b, hsel, hwrite, hready, hresp, ack, slow;
  logic                    req, vtrap, irq;
  logic [31:0]             haddr, hwdata, hrdata, rdat;
  logic [1:0]              htrans;
  logic [VIC_NUM_SRCS-1:0] src_ev;
  logic [7:0]              trap_ev;
  logic [3:0]              ipl;
  logic [23:0]             vaddr;
  logic [6:0]              vnum;
  int                      mismatches = 0;
  int                      cmp_count = 0;
  int                      cyc = 0;
  always #10 clk = ~clk;
  vic_top dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SRC_EVENT_I(src_ev), .TRAP_EVENT_I(trap_ev), .CORE_IPL_I(ipl), .CORE_ACK_I(ack),
    .CORE_REQ_O(req), .VECTOR_ADDR_O(vaddr), .VECTOR_NUM_O(vnum),
    .VECTOR_TRAP_O(vtrap), .IRQ_O(irq));
  vic_core_model core (.clk_i(clk), .rst_b_i(rst_b), .req_i(req), .slow_i(slow),
    .ack_o(ack));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic complete_run();
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rdat, e)
    `CHK(hresp, 1'b0)
  endtask
  task automatic fire(input logic [VIC_NUM_SRCS-1:0] s, input logic [7:0] t);
    src_ev  <= s;
    trap_ev <= t;
    @(posedge clk);
    src_ev  <= '0;
    trap_ev <= 8'h0;
  endtask
  task automatic want(input logic [6:0] n, input logic [23:0] ad, input logic t);
    while (req !== 1'b1) @(posedge clk);
    `CHK(vnum, n)
    `CHK(vaddr, ad)
    `CHK(vtrap, t)
  endtask
  task automatic drain(input logic [31:0] a);
    wr(a, 32'h0);
    while (req !== 1'b0) @(posedge clk);
  endtask
  task automatic quiet();
    repeat (8) @(posedge clk);
    `CHK(req, 1'b0)
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {rst_b, hsel, hwrite, haddr, hwdata, htrans, src_ev, trap_ev, ipl} = '0;
    slow = 1'b1;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(32'h040, 32'h00004444);
    rd(32'h100, 32'h0);
    wr(32'h0d4, 32'h2);
    wr(32'h040, 32'h00005444);
    wr(32'h044, 32'h00004464);
    wr(32'h020, 32'h0000022a);
    fire(118'h28, 8'h0);
    want(7'd5, 24'h00001e, 1'b0);
    drain(32'h0);
    rd(32'h0c4, 32'h00000605);
    `CHK(irq, 1'b1)
    wr(32'h0d0, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    fire(118'h202, 8'h0);
    want(7'd1, 24'h000016, 1'b0);
    drain(32'h0);
    wr(32'h0c0, 32'h8000);
    fire(118'h200, 8'h0);
    want(7'd9, 24'h000126, 1'b0);
    drain(32'h0);
    fire(118'h0, 8'h14);
    want(7'd2, 24'h000108, 1'b1);
    rd(32'h0c8, 32'h00000014);
    wr(32'h0c8, 32'h14);
    drain(32'h0c0);
    ipl <= 4'h4;
    fire(118'h2, 8'h0);
    quiet();
    ipl <= 4'h3;
    want(7'd1, 24'h000016, 1'b0);
    drain(32'h0);
    ipl <= 4'h0;
    wr(32'h040, 32'h00004404);
    fire(118'h2, 8'h0);
    quiet();
    wr(32'h0, 32'h0);
    slow <= 1'b0;
    fire(118'h20, 8'h0);
    want(7'd5, 24'h00001e, 1'b0);
    while (req !== 1'b0) @(posedge clk);
    want(7'd5, 24'h00001e, 1'b0);
    rd(32'h0, 32'h00000020);
    wr(32'h020, 32'h0);
    while (req !== 1'b0) @(posedge clk);
    quiet();
    rd(32'h0, 32'h00000020);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(req, 1'b0)
    `CHK(vaddr, 24'h000000)
    rst_b <= 1'b1;
    @(posedge clk);
    rd(32'h040, 32'h00004444);
    rd(32'h0, 32'h0);
    complete_run();
  end
endmodule

/* vic_core_model.sv */
`timescale 1ns/1ns
module vic_core_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Handshake
  input  wire logic req_i,
  input  wire logic slow_i,
  output logic      ack_o
);
  logic [2:0] wait_r;
  // Accept a standing request, five cycles later than fast when slow
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= 3'h0;
      ack_o  <= 1'b0;
    end else begin
      wait_r <= (req_i && !ack_o) ? wait_r + 3'h1 : 3'h0;
      ack_o  <= req_i && !ack_o && (!slow_i || wait_r == 3'h5);
    end
  end
endmodule

/* vic_monitor.sv */
`timescale 1ns/1ns
module vic_monitor (
  // Clock and reset
  input wire logic        CORE_CLK_I,
  input wire logic        RST_B_I,
  // Bus
  input wire logic        HSEL_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic        HREADYOUT_O,
  // Core side
  input wire logic [3:0]  CORE_IPL_I,
  input wire logic        CORE_ACK_I,
  input wire logic        CORE_REQ_O,
  input wire logic [23:0] VECTOR_ADDR_O,
  input wire logic [6:0]  VECTOR_NUM_O,
  input wire logic        VECTOR_TRAP_O
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  logic take;
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_rd_wait; !HREADYOUT_O ##1 HREADYOUT_O; endsequence
  sequence s_quiet; !CORE_REQ_O [*3]; endsequence
  property p_rd_wait; take && !HWRITE_I |=> s_rd_wait; endproperty
  property p_wr_fast; take && HWRITE_I |=> HREADYOUT_O; endproperty
  property p_req_stands;
    CORE_REQ_O && !CORE_ACK_I |=>
      CORE_REQ_O && $stable(VECTOR_ADDR_O) && $stable(VECTOR_NUM_O);
  endproperty
  property p_fixed_entry; CORE_REQ_O && CORE_ACK_I |=> s_quiet; endproperty
  property p_trap_addr;
    CORE_REQ_O && VECTOR_TRAP_O |-> VECTOR_NUM_O < 7'h08 && VECTOR_ADDR_O[23:9] == 15'h0
      && VECTOR_ADDR_O[7:0] == 8'h04 + {VECTOR_NUM_O, 1'b0};
  endproperty
  property p_src_addr;
    CORE_REQ_O && !VECTOR_TRAP_O |-> VECTOR_NUM_O < 7'h76 && VECTOR_ADDR_O[23:9] == 15'h0
      && VECTOR_ADDR_O[7:0] == 8'h14 + {VECTOR_NUM_O, 1'b0};
  endproperty
  property p_trap_ipl;
    $rose(CORE_REQ_O) && VECTOR_TRAP_O |-> $past(CORE_IPL_I) < 4'h8;
  endproperty
  property p_ipl_max; $rose(CORE_REQ_O) |-> $past(CORE_IPL_I) != 4'hf; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  a_wr_fast: assert property (p_wr_fast) else $error("write not zero wait");
  a_req_stands: assert property (p_req_stands) else $error("request moved");
  a_fixed_entry: assert property (p_fixed_entry) else $error("entry time");
  a_trap_addr: assert property (p_trap_addr) else $error("trap address");
  a_src_addr: assert property (p_src_addr) else $error("source address");
  a_trap_ipl: assert property (p_trap_ipl) else $error("trap level");
  a_ipl_max: assert property (p_ipl_max) else $error("request at top level");
endmodule
bind vic_top vic_monitor u_mon (
  .CORE_CLK_I, .RST_B_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HREADYOUT_O,
  .CORE_IPL_I, .CORE_ACK_I, .CORE_REQ_O, .VECTOR_ADDR_O, .VECTOR_NUM_O, .VECTOR_TRAP_O
);

/* vic_pkg.sv */
package vic_pkg;

  // ****************************************************************
  // Vector table geometry
  // ****************************************************************
  localparam int          VIC_NUM_TRAPS     = 8;
  localparam int          VIC_NUM_SRCS      = 118;
  localparam int          VIC_NUM_VECTORS   = 126;
  localparam logic [23:0] VIC_PRIMARY_BASE  = 24'h000004;
  localparam logic [23:0] VIC_SOURCE_BASE   = 24'h000014;
  localparam logic [23:0] VIC_ALT_OFFSET    = 24'h000100;
  localparam logic [23:0] VIC_RESET_ADDR    = 24'h000000;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [11:0] VIC_FLAG_BASE     = 12'h000;
  localparam logic [11:0] VIC_ENABLE_BASE   = 12'h020;
  localparam logic [11:0] VIC_PRIO_BASE     = 12'h040;
  localparam logic [11:0] VIC_CTRL_TWO_ADDR = 12'h0c0;
  localparam logic [11:0] VIC_LATCH_ADDR    = 12'h0c4;
  localparam logic [11:0] VIC_TRAP_ADDR     = 12'h0c8;
  localparam logic [11:0] VIC_CORE_IPL_ADDR = 12'h0cc;
  localparam logic [11:0] VIC_IRQ_STAT_ADDR = 12'h0d0;
  localparam logic [11:0] VIC_IRQ_MASK_ADDR = 12'h0d4;
  localparam int          VIC_FLAG_REGS     = 8;
  localparam int          VIC_PRIO_REGS     = 30;
  localparam int          VIC_ALT_BIT       = 15;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [2:0]  VIC_PRIO_RESET    = 3'h4;
  localparam logic [3:0]  VIC_TRAP_LEVEL    = 4'h8;
  localparam logic [1:0]  VIC_ENTRY_CYCLES  = 2'h2;

  // ****************************************************************
  // Handshake states
  // ****************************************************************
  typedef enum logic [2:0] {
    VIC_IDLE = 3'b001,
    VIC_REQ  = 3'b010,
    VIC_ACK  = 3'b100
  } vic_state_t;

endpackage

/* vic_resolver.sv */
`timescale 1ns/1ns
module vic_resolver
  import vic_pkg::*;
#(
  parameter int NSRC = 118
) (
  // Requests
  input  wire logic [NSRC-1:0]   pend_i,
  input  wire logic [3*NSRC-1:0] prio_i,
  input  wire logic [7:0]        trap_i,
  // Winner
  output logic                   valid_o,
  output logic [6:0]             vec_o,
  output logic [3:0]             level_o,
  output logic                   is_trap_o
);

  always_comb begin
    valid_o   = 1'b0;
    vec_o     = 7'h00;
    level_o   = 4'h0;
    is_trap_o = 1'b0;
    // Descending scan with >= keeps the lowest index among equals
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_i[i] && prio_i[3*i +: 3] != 3'h0 &&
          {1'b0, prio_i[3*i +: 3]} >= level_o) begin
        valid_o = 1'b1;
        vec_o   = 7'(i);
        level_o = {1'b0, prio_i[3*i +: 3]};
      end
    end
    // Traps are never masked and outrank any user level
    for (int t = 7; t >= 0; t--) begin
      if (trap_i[t]) begin
        valid_o   = 1'b1;
        vec_o     = 7'(t);
        level_o   = VIC_TRAP_LEVEL;
        is_trap_o = 1'b1;
      end
    end
  end

endmodule

/* vic_top.sv */
// Contract
// - All source requests merge into one request line to the core.
// - Primary vector table starts at word address 000004h.
// - 126 vectors: 8 unmaskable traps then up to 118 sources. Traps here run at level 8, so a CORE_IPL_I of 8 or more holds them off.
// - Each vector entry is a 24-bit routine start address.
// - Among equals the lower vector position wins; vector 0 highest.
// - Seven assignable user levels; arbitration first by level.
// - Same level ties are broken by fixed natural order only.
// - Entry and return take a fixed number of cycles for any vector.
// - Alt select bit 15 of control two moves all fetches to alternate table.
// - Alternate entries lie 100h above primary ones, same order.
// - Reset bypasses the controller; fetch starts at 000000h.
// - Trap n lies at 000004h plus 2n; traps 1-4 named, rest reserved.
// - Source n lies at 000014h plus 2n.
// - Flags set by hardware stay until software clears; enables gate them.
// - Flag, enable and priority fields allotted in vector-number order.
// - Priority field selects eight levels; zero never interrupts.
// - On acceptance latch 7-bit vector and 4-bit new level for reading.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module vic_top
  import vic_pkg::*;
#(
  parameter int NSRC = VIC_NUM_SRCS
) (
  // Clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_B_I,
  // AHB-Lite slave
  input  wire logic              HSEL_I,
  input  wire logic [31:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic [31:0]            HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  // Event sources, one-cycle pulses from same clock
  input  wire logic [NSRC-1:0]   SRC_EVENT_I,
  input  wire logic [7:0]        TRAP_EVENT_I,
  // Core side
  input  wire logic [3:0]        CORE_IPL_I,
  input  wire logic              CORE_ACK_I,
  output logic                   CORE_REQ_O,
  output logic [23:0]            VECTOR_ADDR_O,
  output logic [6:0]             VECTOR_NUM_O,
  output logic                   VECTOR_TRAP_O,
  // Interrupt to system
  output logic                   IRQ_O
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [NSRC-1:0]   flag_r;
  logic [NSRC-1:0]   enable_r;
  logic [3*NSRC-1:0] prio_r;
  logic [7:0]        trap_r;
  logic              alt_r;
  logic [6:0]        acc_vec_r;
  logic [3:0]        acc_lvl_r;
  logic [3:0]        req_lvl_r;
  logic [1:0]        stat_r;
  logic [1:0]        mask_r;
  vic_state_t        state_r;
  logic [1:0]        cnt_r;
  logic              wr_pend_r;
  logic              rd_pend_r;
  logic [11:0]       addr_r;

  function automatic logic [23:0] vec_addr(input logic [6:0] n, input logic trap,
                                          input logic alt);
    logic [23:0] base;
    base = trap ? VIC_PRIMARY_BASE : VIC_SOURCE_BASE;
    return base + {16'h0000, n, 1'b0} + (alt ? VIC_ALT_OFFSET : 24'h000000);
  endfunction

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  wire [NSRC-1:0] pend = flag_r & enable_r;
  logic           win_valid;
  logic [6:0]     win_vec;
  logic [3:0]     win_lvl;
  logic           win_trap;

  vic_resolver #(
    .NSRC (NSRC)
  ) u_resolver (
    .pend_i    (pend),
    .prio_i    (prio_r),
    .trap_i    (trap_r),
    .valid_o   (win_valid),
    .vec_o     (win_vec),
    .level_o   (win_lvl),
    .is_trap_o (win_trap)
  );

  wire want_irq = win_valid && (win_lvl > CORE_IPL_I);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire        take   = HSEL_I && HREADY_I && HTRANS_I[1];
  wire [11:0] wa     = addr_r;
  wire        do_wr  = wr_pend_r;
  wire [31:0] wd     = HWDATA_I;
  wire        in_flg = wa < VIC_ENABLE_BASE;
  wire        in_en  = wa >= VIC_ENABLE_BASE && wa < VIC_PRIO_BASE;
  wire        in_pr  = wa >= VIC_PRIO_BASE && wa < VIC_CTRL_TWO_ADDR;
  wire [4:0]  widx   = 5'(wa[6:2] - (in_en ? 5'h08 : 5'h00));
  wire [4:0]  pidx   = 5'((wa - VIC_PRIO_BASE) >> 2);

  function automatic logic [15:0] slice16(input logic [NSRC-1:0] v, input logic [4:0] k);
    logic [127:0] w;
    w = '0;
    w[NSRC-1:0] = v;
    return w[16*k[2:0] +: 16];
  endfunction

  function automatic logic [15:0] prio16(input logic [3*NSRC-1:0] v, input logic [4:0] k);
    logic [15:0] r;
    r = 16'h0000;
    for (int j = 0; j < 4; j++) begin
      if (4*k + j < NSRC) begin
        r[4*j +: 3] = v[3*(4*k+j) +: 3];
      end
    end
    return r;
  endfunction

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_flg) begin
      rd_val = {16'h0000, slice16(flag_r, widx)};
    end else if (in_en) begin
      rd_val = {16'h0000, slice16(enable_r, widx)};
    end else if (in_pr && pidx < 5'(VIC_PRIO_REGS)) begin
      rd_val = {16'h0000, prio16(prio_r, pidx)};
    end else begin
      case (wa)
        VIC_CTRL_TWO_ADDR: rd_val = {16'h0000, alt_r, 15'h0000};
        VIC_LATCH_ADDR:    rd_val = {20'h00000, acc_lvl_r, 1'b0, acc_vec_r};
        VIC_TRAP_ADDR:     rd_val = {24'h000000, trap_r};
        VIC_CORE_IPL_ADDR: rd_val = {28'h0000000, CORE_IPL_I};
        VIC_IRQ_STAT_ADDR: rd_val = {30'h0, stat_r};
        VIC_IRQ_MASK_ADDR: rd_val = {30'h0, mask_r};
        default:           rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Flags: hardware set wins over software clear
  // ****************************************************************
  logic [NSRC-1:0] flag_nxt;
  logic [NSRC-1:0] enable_nxt;
  logic [3*NSRC-1:0] prio_nxt;
  always_comb begin
    flag_nxt   = flag_r;
    enable_nxt = enable_r;
    prio_nxt   = prio_r;
    for (int i = 0; i < NSRC; i++) begin
      if (do_wr && in_flg && widx == 5'(i / 16)) begin
        flag_nxt[i] = wd[i % 16];
      end
      if (do_wr && in_en && widx == 5'(i / 16)) begin
        enable_nxt[i] = wd[i % 16];
      end
      if (do_wr && in_pr && pidx == 5'(i / 4)) begin
        prio_nxt[3*i +: 3] = wd[4*(i % 4) +: 3];
      end
    end
    flag_nxt = flag_nxt | SRC_EVENT_I;
  end

  wire accept = (state_r == VIC_REQ) && CORE_ACK_I;
  wire [1:0] ev = {accept, |TRAP_EVENT_I};

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flag_r    <= '0;
      enable_r  <= '0;
      prio_r    <= {NSRC{VIC_PRIO_RESET}};
      trap_r    <= 8'h00;
      alt_r     <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end else begin
      flag_r    <= flag_nxt;
      enable_r  <= enable_nxt;
      prio_r    <= prio_nxt;
      trap_r    <= (trap_r & ~((do_wr && wa == VIC_TRAP_ADDR) ? wd[7:0] : 8'h00))
                   | TRAP_EVENT_I;
      if (do_wr && wa == VIC_CTRL_TWO_ADDR) begin
        alt_r <= wd[VIC_ALT_BIT];
      end
      wr_pend_r <= take && HWRITE_I;
      rd_pend_r <= take && !HWRITE_I;
      if (take) begin
        addr_r <= HADDR_I[11:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      IRQ_O  <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~((do_wr && wa == VIC_IRQ_STAT_ADDR) ? wd[1:0] : 2'h0)) | ev;
      if (do_wr && wa == VIC_IRQ_MASK_ADDR) begin
        mask_r <= wd[1:0];
      end
      IRQ_O <= |(stat_r & mask_r);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HRDATA_O    <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HRDATA_O    <= (take && !HWRITE_I) ? 32'h0000_0000 : rd_val;
      HREADYOUT_O <= !(take && !HWRITE_I);
      HRESP_O     <= 1'b0;
    end
  end

  // ****************************************************************
  // Core handshake, fixed entry latency
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r       <= VIC_IDLE;
      cnt_r         <= 2'h0;
      CORE_REQ_O    <= 1'b0;
      VECTOR_ADDR_O <= VIC_RESET_ADDR;
      VECTOR_NUM_O  <= 7'h00;
      VECTOR_TRAP_O <= 1'b0;
      acc_vec_r     <= 7'h00;
      acc_lvl_r     <= 4'h0;
      req_lvl_r     <= 4'h0;
    end else begin
      case (state_r)
        VIC_IDLE: begin
          CORE_REQ_O <= want_irq;
          if (want_irq) begin
            VECTOR_ADDR_O <= vec_addr(win_vec, win_trap, alt_r);
            VECTOR_NUM_O  <= win_vec;
            VECTOR_TRAP_O <= win_trap;
            req_lvl_r     <= win_lvl;
            state_r       <= VIC_REQ;
          end
        end
        VIC_REQ: begin
          if (CORE_ACK_I) begin
            CORE_REQ_O <= 1'b0;
            acc_vec_r  <= VECTOR_NUM_O;
            acc_lvl_r  <= req_lvl_r;
            cnt_r      <= VIC_ENTRY_CYCLES;
            state_r    <= VIC_ACK;
          end
        end
        VIC_ACK: begin
          cnt_r <= cnt_r - 2'h1;
          if (cnt_r == 2'h1) begin
            state_r <= VIC_IDLE;
          end
        end
        default: begin
          state_r    <= VIC_IDLE;
          CORE_REQ_O <= 1'b0;
        end
      endcase
    end
  end

endmodule
